// *** instr_unit_error_classifier_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin fails++; \
   $display("MISMATCH %s exp %h got %h", nm, exp, got); end end
module instr_unit_error_classifier_tb_top;
   import iuec_pkg::*;
   logic        ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rdat;
   wire  logic [31:0] prdata, ind;
   wire  logic  pready, pslverr, irq;
   wire  iuec_steps_t steps;
   wire  iuec_class_t cls;
   wire  iuec_err_t   err;
   wire  iuec_op_t    op;
   iuec_steps_t s = '0;
   iuec_class_t c = '0;
   iuec_err_t   e = '0;
   iuec_op_t    o = '0;
   int fails = 0, compares = 0, cyc = 0, tn = 0;
   iuec_classifier u_dut (.i_ref_clk(ref_clk), .i_rst(rst), .i_steps(steps), .i_cls(cls), .i_err(err),
      .i_op(op), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .o_irq(irq), .o_indicator(ind));
   iuec_seq_model u_seq (.i_ref_clk(ref_clk), .o_steps(steps), .o_cls(cls), .o_err(err), .o_op(op));
   always #50 ref_clk = ~ref_clk;
   task final_report;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // hang guard, far above the few hundred cycles needed
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         final_report;
      end
   end
   // one apb transfer; request held until pready is seen high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      rdat = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge ref_clk);
   endtask
   // clear flags, send one burst, look three edges after the latch
   task fire(input logic [31:0] exp);
      apb(1'b1, IUEC_IND_OFS, 32'hFFFF_FFFF);
      apb(1'b1, IUEC_STAT_OFS, 32'h0000_0007);
      u_seq.pulse(s, c, e, o);
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK("indicator", exp, ind)
      tn++;
      $display("test %0d done", tn);
      s = '0;
      c = '0;
      e = '0;
      o = '0;
   endtask
   initial begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      apb(1'b0, IUEC_CTRL_OFS, 32'h0);
      `CHK("ctrl", 32'h0000_0001, rdat)
      apb(1'b0, 8'h14, 32'h0);
      `CHK("unmapped", 1'b1, er)
      e.index_arith_fault = 1'b1; e.z_half_controls_active = 1'b1; s.cnt1 = 1'b1;
      fire(32'h0000_0004);
      e.index_arith_fault = 1'b1; s.wbc_test = 1'b1;
      fire(32'h0000_0000);
      e.uncorrectable_fault = 1'b1; c.tmt_swp = 1'b1; s.ldx3 = 1'b1; s.emf3_m = 1'b1;
      fire(32'h0000_0001);
      e.second_buffer_mem_fault = 1'b1; e.second_word_count_step = 1'b1;
      fire(32'h0000_0004);
      e.uncorrectable_fault = 1'b1; e.first_word_count_step = 1'b1; e.correction_strobe = 1'b1;
      fire(32'h0000_0004);
      o.zop = 9'h001; o.ifield_zero = 1'b1; o.progressive_indexing = 1'b1; o.gate_varlen_to_lookahead = 1'b1;
      fire(32'h0000_8000);
      e.memory_fault = 1'b1; c.tmt_swp = 1'b1; s.ldx3 = 1'b1;
      fire(32'h0000_0001);
      e.memory_fault = 1'b1;
      fire(32'h0000_0004);
      e.instr_box_parity_fault = 1'b1; e.branch_ok = 1'b1; c.tmt_swp = 1'b1; s.chk4 = 1'b1;
      fire(32'h0000_0001);
      e.instr_box_parity_fault = 1'b1; c.exid_grp = 1'b1; s.ldx1 = 1'b1;
      fire(32'h0000_0004);
      e.index_addr_check = 1'b1; c.lg = 1'b1; s.xsf1 = 1'b1;
      fire(32'h0000_0004);
      e.uncorrectable_fault = 1'b1; c.r_rcz = 1'b1; s.chk1 = 1'b1;
      fire(32'h0000_0004);
      e.first_buffer_mem_fault = 1'b1; e.use_first_buf = 1'b1; s.chk1 = 1'b1;
      fire(32'h0000_0001);
      e.second_buffer_mem_fault = 1'b1; e.use_second_buf = 1'b1; s.chk1 = 1'b1;
      fire(32'h0000_0004);
      e.first_buffer_mem_fault = 1'b1; e.operand_addr_bit17 = 1'b1; s.ldx5 = 1'b1;
      fire(32'h0000_0001);
      e.first_buffer_mem_fault = 1'b1; s.ldx5 = 1'b1;
      fire(32'h0000_0004);
      e.index_addr_check = 1'b1;
      fire(32'h0000_0001);
      apb(1'b0, IUEC_STAT_OFS, 32'h0);
      `CHK("status", 32'h0000_0001, rdat)
      `CHK("irq masked", 1'b0, irq)
      apb(1'b1, IUEC_MASK_OFS, 32'h0000_0001);
      `CHK("irq open", 1'b1, irq)
      apb(1'b1, IUEC_STAT_OFS, 32'h0000_0001);
      `CHK("irq cleared", 1'b0, irq)
      apb(1'b1, IUEC_CTRL_OFS, 32'h0);
      e.index_arith_fault = 1'b1; e.z_half_controls_active = 1'b1; s.mod_zl = 1'b1;
      fire(32'h0000_0000);
      apb(1'b0, IUEC_LATCH_OFS, 32'h0);
      `CHK("latch held", 32'h0000_0002, rdat)
      apb(1'b1, IUEC_CTRL_OFS, 32'h0000_0001);
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK("late sample", 32'h0000_0004, ind)
      // mid-run reset must drop a latch that sampling never consumed
      apb(1'b1, IUEC_CTRL_OFS, 32'h0);
      e.uncorrectable_fault = 1'b1; c.r_rcz = 1'b1; s.chk1 = 1'b1;
      u_seq.pulse(s, c, e, o);
      s = '0;
      c = '0;
      e = '0;
      apb(1'b0, IUEC_LATCH_OFS, 32'h0);
      `CHK("latch before reset", 32'h0000_0002, rdat)
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      @(negedge ref_clk);
      `CHK("reset ind", IUEC_IND_RST, ind)
      apb(1'b0, IUEC_LATCH_OFS, 32'h0);
      `CHK("reset latch", 32'h0000_0000, rdat)
      apb(1'b0, IUEC_CTRL_OFS, 32'h0);
      `CHK("reset ctrl", 32'h0000_0001, rdat)
      final_report;
   end
endmodule
`default_nettype wire

// *** iuec_classifier.sv ***
// Behaviour
// - unlocatable latch sampled sets machine fault bit0
// - locatable latch sampled sets reject bit2
// - index arith fault with z controls sets locatable
// - uncorrectable on listed steps sets unlocatable
// - uncorrectable on check/load-index sets locatable
// - buffer faults with word-count step set locatable
// - index address check on fetch steps sets locatable
// - undefined opcode or special cases raise bad opcode
// - parity fault on listed steps sets locatable
// - parity fault, transmit/swap/rename steps, sets unlocatable
// - memory fault with load-index/store sets unlocatable
// - buffer memory check routed by buffer, step, bit17
// - address check unlocatable only if not locatable
// - memory fault locatable when unlocatable not conditioned
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module iuec_classifier (
   input  wire logic                 i_ref_clk,  // 10 mhz processor clock
   input  wire logic                 i_rst,      // synchronous reset, high
   input  wire iuec_pkg::iuec_steps_t i_steps,   // sequencer step strobes
   input  wire iuec_pkg::iuec_class_t i_cls,     // instruction class decodes
   input  wire iuec_pkg::iuec_err_t   i_err,     // error sources
   input  wire iuec_pkg::iuec_op_t    i_op,      // opcode decode inputs
   input  wire logic                 psel,       // apb select
   input  wire logic                 penable,    // apb enable
   input  wire logic                 pwrite,     // apb direction
   input  wire logic [7:0]           paddr,      // apb byte address
   input  wire logic [31:0]          pwdata,     // apb write data
   output logic [31:0]               prdata,     // apb read data
   output logic                      pready,     // apb ready
   output logic                      pslverr,    // apb error
   output logic                      o_irq,      // level interrupt
   output logic [31:0]               o_indicator // indicator register
);
   import iuec_pkg::*;

   iuec_steps_t s;                         // short alias for steps
   iuec_class_t c;                         // short alias for classes
   iuec_err_t   e;                         // short alias for errors
   assign s = i_steps;
   assign c = i_cls;
   assign e = i_err;

   logic        unlocatable_fault_latch;   // machine-fault source
   logic        locatable_fault_latch;     // reject source
   logic        bad_opcode_latch;          // invalid opcode source
   logic [31:0] ind_r;                     // indicator register
   logic [2:0]  stat_r;                    // sticky event status
   logic [2:0]  mask_r;                    // interrupt enables
   logic        samp_en_r;                 // sampling enabled by software
   iuec_state_t st_r;                      // sampler state
   iuec_state_t st_nxt;                    // next sampler state

   wire iau_steps = s.cnt1 | s.ram1 | s.lam1 | s.add1 | s.add2 | s.add3 | s.add4 | s.add5 |
                    s.yl_zr | s.yl_zl | s.yr_zr | s.yr_zl | s.mod_zr | s.mod_zl | s.wbc_test;
   wire set_iau_loc = e.index_arith_fault & e.z_half_controls_active & iau_steps;

   wire unc_nloc = e.uncorrectable_fault & (
                   (c.tmt_swp & s.ldx3 & s.emf3_m) |
                   (c.rename & s.ldx4) |
                   (c.swp & s.ldx4 & s.emf4_m) |
                   (c.sic_bstore & s.ldx5) |
                   (s.emf3_m & s.lst3) |
                   (s.emf4_m & s.lst4));

   wire unc_loc = e.uncorrectable_fault & (
                  (c.exid_dxrn & s.chk1) |
                  (c.r_rcz & s.chk1) |
                  (c.exop_grp & s.ldx3) |
                  (c.reset_grp & s.ldx4) |
                  (~c.sic_bstore & s.ldx5) |
                  (c.exop_grp & s.ldx4 & s.emf4_m));

   wire buf1_loc = e.first_word_count_step &
                   (e.first_buffer_mem_fault | (e.uncorrectable_fault & e.correction_strobe));
   wire buf2_loc = e.second_word_count_step &
                   (e.second_buffer_mem_fault | (e.uncorrectable_fault & e.correction_strobe));

   wire iac_cond = (c.lg & s.xsf1) |
                   ((c.lg | c.kv_kc | c.dx_free) & s.xsf1) |
                   (c.store_grp & s.xsf3) |
                   (c.exop & s.xsf4) |
                   (c.reset_grp & s.xsf5);
   wire iac_loc  = e.index_addr_check & iac_cond;
   wire iac_nloc = e.index_addr_check & ~iac_cond;

   wire par_loc = e.instr_box_parity_fault & (
                  (c.exid_grp & s.ldx1) |
                  (c.exop_grp & s.ldx4 & s.emf4_m) |
                  (c.exop & s.chk4) |
                  (c.reset_grp & s.chk5) |
                  (c.r_rcz & s.chk6) |
                  (c.lg_dx_nrn & s.chk6) |
                  ((s.mod_zl | s.mod_zr) & e.progressive_idx_in_y &
                   e.fullword_not_store & c.xfer_dec));

   wire par_nloc = e.instr_box_parity_fault & e.branch_ok & (
                   (c.tmt_swp & s.chk4) |
                   (c.swp & s.chk5) |
                   (c.rename & s.lst1) |
                   (s.lst3 & s.lst4 & s.emf3_nm) |
                   (s.lop3 & s.emf4_nm) |
                   (c.tmt_swp & c.any_sic_br & ~c.z_xa & c.no_op) |
                   (s.ldx3 & s.emf3_nm) |
                   (c.swp & s.ldx4 & s.emf4_nm));

   wire mem_nloc = e.memory_fault & (
                   (c.tmt_swp & s.ldx3) |
                   (c.swp & s.ldx4) |
                   (c.rename & s.ldx4) |
                   s.lst3 | s.lst4);

   wire ybuf_mc   = e.first_buffer_mem_fault | e.second_buffer_mem_fault;
   wire ymc_nloc  = ybuf_mc & (
                    (e.use_first_buf & s.chk1) |
                    (e.use_first_buf & c.exid_grp & s.ldx1) |
                    (e.use_first_buf & s.ldx4) |
                    (e.operand_addr_bit17 & (s.ldx5 | s.ldx6)) |
                    s.lst3 | s.ldx3);
   wire ymc_loc   = ybuf_mc & ~ymc_nloc & (
                    (e.use_second_buf & (s.chk1 | (c.exid_grp & s.ldx1) | s.ldx4)) |
                    (c.swp_exop & s.ldx4) |
                    (~e.operand_addr_bit17 & (s.ldx5 | s.ldx6)));
   wire mem_loc   = e.memory_fault & ~mem_nloc;

   wire set_nloc = unc_nloc | iac_nloc | par_nloc | mem_nloc | ymc_nloc;
   wire set_loc  = set_iau_loc | unc_loc | buf1_loc | buf2_loc | iac_loc | par_loc |
                   ymc_loc | mem_loc;

   wire [8:0] z = i_op.zop;
   wire vfl_bad = i_op.gate_varlen_to_lookahead & (
                  (z[8] & z[6] & z[4] & ~z[3] & ~z[2] & ~z[1] & ~z[0] & i_op.zfw) |
                  (z[8] & z[7] & ~z[6] & ~z[5] & z[4] & ~z[3] & ~z[2] & ~z[1] & ~z[0] & i_op.zfw) |
                  (z[4] & z[3] & z[2] & z[1] & z[0]) |
                  (z[5] & ~z[4] & z[3] & z[2] & ~z[1] & z[0] & i_op.zfw & i_op.immediate) |
                  (z[0] & i_op.ifield_zero & i_op.progressive_indexing));
   // opcode decode, floating point
   wire fp_bad  = i_op.gate_float_to_lookahead & (
                  (z[6] & z[5] & z[4] & z[3]) |
                  (z[6] & z[5] & z[3] & ~z[2]));
   wire set_op  = vfl_bad | fp_bad;

   // sampler moves latches into the indicator once enabled
   always_comb begin
      case (st_r)
         IUEC_IDLE:   st_nxt = samp_en_r ? IUEC_SAMPLE : IUEC_IDLE;
         IUEC_SAMPLE: st_nxt = samp_en_r ? IUEC_SAMPLE : IUEC_IDLE;
         default:     st_nxt = IUEC_IDLE;
      endcase
   end
   wire sample = (st_r == IUEC_SAMPLE);

   // fault latches; a set in the sampling cycle wins over the clear
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         unlocatable_fault_latch <= 1'b0;
         locatable_fault_latch   <= 1'b0;
         bad_opcode_latch        <= 1'b0;
      end else begin
         unlocatable_fault_latch <= set_nloc | (unlocatable_fault_latch & ~sample);
         locatable_fault_latch   <= set_loc | (locatable_fault_latch & ~sample);
         bad_opcode_latch        <= set_op | (bad_opcode_latch & ~sample);
      end
   end

   // apb decode
   wire acc   = psel & penable;
   wire wr    = acc & pwrite;
   wire a_ctl = (paddr == IUEC_CTRL_OFS);
   wire a_ind = (paddr == IUEC_IND_OFS);
   wire a_st  = (paddr == IUEC_STAT_OFS);
   wire a_msk = (paddr == IUEC_MASK_OFS);
   wire a_lat = (paddr == IUEC_LATCH_OFS);
   wire mapped = a_ctl | a_ind | a_st | a_msk | a_lat;
   // events only count when the indicator bit is actually raised
   wire [2:0] ev = {sample & bad_opcode_latch, sample & locatable_fault_latch,
                    sample & unlocatable_fault_latch};
   wire [31:0] ind_set = {16'h0000, bad_opcode_latch, 12'h000, locatable_fault_latch,
                          1'b0, unlocatable_fault_latch};
   wire [31:0] ind_keep = (wr & a_ind) ? (ind_r & ~pwdata) : ind_r;

   // indicator: written ones clear, sampled latches set
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         ind_r <= IUEC_IND_RST;
      end else begin
         ind_r <= ind_keep | (sample ? ind_set : 32'h0000_0000);
      end
   end

   // control, mask and sticky status
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         samp_en_r <= IUEC_CTRL_RST[0];
         mask_r    <= IUEC_MASK_RST;
         stat_r    <= 3'h0;
         st_r      <= IUEC_IDLE;
      end else begin
         st_r <= st_nxt;
         if (wr & a_ctl) begin
            samp_en_r <= pwdata[0];
         end
         if (wr & a_msk) begin
            mask_r <= pwdata[2:0];
         end
         // new events win over a write-one clear
         stat_r <= ev | (stat_r & ~((wr & a_st) ? pwdata[2:0] : 3'h0));
      end
   end

   // read mux, registered on the setup cycle
   wire [31:0] rd_mux = a_ctl ? {31'h0, samp_en_r} :
                        a_ind ? ind_r :
                        a_st  ? {29'h0, stat_r} :
                        a_msk ? {29'h0, mask_r} :
                        a_lat ? {29'h0, bad_opcode_latch, locatable_fault_latch,
                                 unlocatable_fault_latch} : 32'h0000_0000;
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         prdata <= 32'h0000_0000;
      end else if (psel & ~penable & ~pwrite) begin
         prdata <= rd_mux;
      end
   end

   // zero-wait answer; unmapped addresses flag an error
   assign pready      = 1'b1;
   assign pslverr     = acc & ~mapped;
   assign o_irq       = |(stat_r & mask_r);
   assign o_indicator = ind_r;
endmodule
`default_nettype wire

// *** iuec_classifier_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
module iuec_classifier_monitor (
   input wire logic                  i_ref_clk,   // clock
   input wire logic                  i_rst,       // reset
   input wire iuec_pkg::iuec_steps_t i_steps,     // steps
   input wire iuec_pkg::iuec_class_t i_cls,       // classes
   input wire iuec_pkg::iuec_err_t   i_err,       // errors
   input wire iuec_pkg::iuec_op_t    i_op,        // opcode
   input wire logic                  psel,        // apb select
   input wire logic                  penable,     // apb enable
   input wire logic                  pwrite,      // apb direction
   input wire logic [7:0]            paddr,       // apb address
   input wire logic [31:0]           pwdata,      // apb data
   input wire logic                  pready,      // apb ready
   input wire logic                  pslverr,     // apb error
   input wire logic                  o_irq,       // interrupt
   input wire logic [31:0]           o_indicator  // indicator
);
   import iuec_pkg::*;
   logic ctrl_r; // mirror of the sample enable
   wire acc = psel && penable;
   wire ctrl_wr = acc && pwrite && (paddr == IUEC_CTRL_OFS);
   wire ind_clr = acc && pwrite && (paddr == IUEC_IND_OFS);
   wire smp_on = ctrl_r && !ctrl_wr; // enable known for the next two edges
   wire mapped = paddr inside {IUEC_CTRL_OFS, IUEC_IND_OFS, IUEC_STAT_OFS, IUEC_MASK_OFS, IUEC_LATCH_OFS};
   // track writes to the control word
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) ctrl_r <= IUEC_CTRL_RST[0];
      else if (ctrl_wr) ctrl_r <= pwdata[0];
   end
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   property p_rst; $fell(i_rst) |-> (o_indicator == 32'h0) && !o_irq; endproperty
   property p_rdy; acc |-> pready; endproperty
   property p_err; acc |-> (pslverr == !mapped); endproperty
   property p_iau; smp_on && i_err.index_arith_fault && i_err.z_half_controls_active
      && (i_steps.cnt1 || i_steps.mod_zl || i_steps.wbc_test) |-> ##2 o_indicator[IUEC_IJ_BIT]; endproperty
   property p_unc; smp_on && i_err.uncorrectable_fault && i_cls.tmt_swp && i_steps.ldx3 && i_steps.emf3_m
      |-> ##2 o_indicator[IUEC_MK_BIT]; endproperty
   property p_buf; smp_on && i_err.second_buffer_mem_fault && i_err.second_word_count_step
      |-> ##2 o_indicator[IUEC_IJ_BIT]; endproperty
   property p_op; smp_on && i_op.zop[0] && i_op.ifield_zero && i_op.progressive_indexing
      && i_op.gate_varlen_to_lookahead |-> ##2 o_indicator[IUEC_OP_BIT]; endproperty
   property p_mem; smp_on && i_err.memory_fault && i_cls.tmt_swp && i_steps.ldx3
      |-> ##2 o_indicator[IUEC_MK_BIT]; endproperty
   property p_hold; o_indicator[IUEC_MK_BIT] && !ind_clr |=> o_indicator[IUEC_MK_BIT]; endproperty
   // the sampler lags the enable by one edge, so the cycle right after a disabling write may still sample
   property p_off; !ctrl_r && !$past(ctrl_r) && !ctrl_wr && !ind_clr |=> $stable(o_indicator); endproperty
   a_rst: assert property (p_rst) else $error("state not clear after reset");
   a_rdy: assert property (p_rdy) else $error("ready low in access");
   a_err: assert property (p_err) else $error("error flag wrong for address");
   a_iau: assert property (p_iau) else $error("index fault not reported");
   a_unc: assert property (p_unc) else $error("uncorrectable not reported");
   a_buf: assert property (p_buf) else $error("buffer fault not reported");
   a_op: assert property (p_op) else $error("bad opcode not reported");
   a_mem: assert property (p_mem) else $error("memory fault not reported");
   a_hold: assert property (p_hold) else $error("machine flag dropped");
   a_off: assert property (p_off) else $error("indicator moved while disabled");
   c_irq: cover property ($rose(o_irq));
   c_err: cover property (acc && pslverr);
   c_op: cover property ($rose(o_indicator[IUEC_OP_BIT]));
endmodule
bind iuec_classifier iuec_classifier_monitor u_mon (.i_ref_clk, .i_rst, .i_steps, .i_cls, .i_err, .i_op,
   .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .o_irq, .o_indicator);
`default_nettype wire

// *** iuec_pkg.sv ***
package iuec_pkg;
   // apb register byte offsets
   localparam logic [7:0] IUEC_CTRL_OFS   = 8'h00;
   localparam logic [7:0] IUEC_IND_OFS    = 8'h04;
   localparam logic [7:0] IUEC_STAT_OFS   = 8'h08;
   localparam logic [7:0] IUEC_MASK_OFS   = 8'h0C;
   localparam logic [7:0] IUEC_LATCH_OFS  = 8'h10;
   // indicator register bit positions
   localparam int IUEC_MK_BIT = 0;
   localparam int IUEC_IJ_BIT = 2;
   localparam int IUEC_OP_BIT = 15;
   // interrupt status bit positions
   localparam int IUEC_ST_MK  = 0;
   localparam int IUEC_ST_IJ  = 1;
   localparam int IUEC_ST_OP  = 2;
   // reset values
   localparam logic [31:0] IUEC_IND_RST  = 32'h0000_0000;
   localparam logic [2:0]  IUEC_MASK_RST = 3'h0;
   localparam logic [0:0]  IUEC_CTRL_RST = 1'h1;
   // sampler states
   typedef enum logic [1:0] {
      IUEC_IDLE   = 2'b00,
      IUEC_SAMPLE = 2'b01
   } iuec_state_t;
   // step strobes from the sequencers
   typedef struct packed {
      logic cnt1, cnt1m, ram1, lam1, add1, add1m, add2, add3, add4, add5;
      logic yl_zr, yl_zl, yr_zr, yr_zl, mod_zr, mod_zl, wbc_test;
      logic ldx1, ldx3, ldx4, ldx5, ldx6;
      logic chk1, chk4, chk5, chk6;
      logic lst1, lst3, lst4, lop3;
      logic emf3_m, emf4_m, emf3_nm, emf4_nm;
      logic xsf1, xsf3, xsf4, xsf5;
   } iuec_steps_t;
   // instruction class decodes
   typedef struct packed {
      logic tmt_swp;      // transmit or swap
      logic swp;          // swap only
      logic rename;
      logic sic_bstore;   // branch-store variants
      logic any_sic_br;
      logic no_op;
      logic z_xa;
      logic exid_grp;     // exid/lx/sx/rn/sv/sc/sr/sad group
      logic exop_grp;     // exop + exid op
      logic exop;
      logic swp_exop;     // swap + exop + exid op
      logic reset_grp;    // r/rcz + icr + px group
      logic r_rcz;
      logic lg_dx_nrn;
      logic exid_dxrn;
      logic lg, kv_kc, dx_free, store_grp;
      logic xfer_dec;     // transfer or decrement of z halves
   } iuec_class_t;
   // error sources
   typedef struct packed {
      logic index_arith_fault;
      logic z_half_controls_active;
      logic uncorrectable_fault;
      logic instr_box_parity_fault;
      logic memory_fault;
      logic first_buffer_mem_fault;
      logic second_buffer_mem_fault;
      logic first_word_count_step;
      logic second_word_count_step;
      logic correction_strobe;
      logic use_first_buf;
      logic use_second_buf;
      logic operand_addr_bit17;
      logic index_addr_check;
      logic branch_ok;
      logic progressive_idx_in_y;
      logic fullword_not_store;
   } iuec_err_t;
   // opcode decode inputs
   typedef struct packed {
      logic [8:0] zop;    // opcode bits 51..59, zop[8] is bit 51
      logic zfw;
      logic ifield_zero;
      logic progressive_indexing;
      logic immediate;
      logic gate_varlen_to_lookahead;
      logic gate_float_to_lookahead;
   } iuec_op_t;
endpackage

// *** iuec_seq_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// sequencer stand-in: strobes and decodes stand for one cycle only
module iuec_seq_model (
   input  wire logic                  i_ref_clk, // processor clock
   output var  iuec_pkg::iuec_steps_t o_steps,   // step strobes
   output var  iuec_pkg::iuec_class_t o_cls,     // class decodes
   output var  iuec_pkg::iuec_err_t   o_err,     // error sources
   output var  iuec_pkg::iuec_op_t    o_op       // opcode decode
);
   import iuec_pkg::*;
   // quiet until told otherwise
   initial begin
      o_steps = '0;
      o_cls = '0;
      o_err = '0;
      o_op = '0;
   end
   // one-cycle burst; a held strobe would set the latch twice
   task automatic pulse(input iuec_steps_t s, input iuec_class_t c, input iuec_err_t e, input iuec_op_t o);
      @(posedge i_ref_clk);
      o_steps <= s;
      o_cls <= c;
      o_err <= e;
      o_op <= o;
      @(posedge i_ref_clk);
      o_steps <= '0;
      o_cls <= '0;
      o_err <= '0;
      o_op <= '0;
   endtask
endmodule
`default_nettype wire
